/* File: src/pac_pkg.sv */
package pac_pkg;
  // register byte addresses
  localparam logic [3:0]  TRIM_BANK_ADDR   = 4'h0;
  localparam logic [3:0]  LINE_LAYOUT_ADDR = 4'h4;
  // first register fields
  localparam int REV_LSB     = 0;
  localparam int DELAY_LSB   = 12;
  localparam int KIND_LSB    = 16;
  localparam int LOWBYTE_BIT = 20;
  localparam int CLIP_BIT    = 21;
  localparam int SPARE_BIT   = 22;
  localparam int CLEAR_BIT   = 23;
  localparam int BANK_LSB    = 24;
  localparam int DOUBLER_LSB = 30;
  // second register fields
  localparam int ACTIVE_CLOCKS_PER_LINE_LSB    = 0;
  localparam int LAYOUT_LSB  = 17;
  // widths
  localparam int ACTIVE_CLOCKS_PER_LINE_W      = 17;
  localparam int BANK_W      = 6;
  localparam int MAX_DELAY   = 7;
  // clip limits
  localparam logic [7:0] CLIP_HIGH = 8'hF0;
  localparam logic [7:0] CLIP_LOW  = 8'h0F;
  // doubler codes
  localparam logic [1:0] MUL_ONE = 2'h0;
  localparam logic [1:0] MUL_TWO = 2'h1;
  // reset values
  localparam logic [31:0] TRIM_BANK_RST   = 32'h0000_0000;
  localparam logic [31:0] LINE_LAYOUT_RST = 32'h0000_0000;
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // layout codes
  typedef enum logic [4:0] {
    LAY_ONE_TAP, LAY_2T_OEP, LAY_2T_OEL, LAY_2T_SEG, LAY_2T_SEG_RI, LAY_4T_SEG,
    LAY_4T_OEP_RI, LAY_4Q_RI_BU, LAY_2CAM_1T, LAY_2CAM_OEP, LAY_2CAM_SEG_RI,
    LAY_2CAM_SEG, LAY_2CAM_OEL, LAY_8T_SEG, LAY_MOS_1T, LAY_MOS_OEP, LAY_MOS_2TS,
    LAY_4WI, LAY_2T_OEP_INV, LAY_1T_INV, LAY_8WI, LAY_MOS_2TS_RI, LAY_4TS_2RI,
    LAY_8TS_OEP_4RI, LAY_10WI
  } pac_layout_e;

  // pixel beat on the video path
  typedef struct packed {
    logic        lineValid;
    logic [15:0] data;
  } pac_pixel_s;
endpackage

/* File: src/pac_fifo.sv */
module pac_fifo #(
  parameter int WIDTH = 17,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] inData,
  input  wire logic             inValid,
  output logic                  inReady,
  output logic      [WIDTH-1:0] outData,
  output logic                  outValid,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);
  initial
  begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be a power of two");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wrPtr;
  logic [AW:0]      rdPtr;
  wire  [AW:0]      fill = wrPtr - rdPtr;
  wire              push = inValid && inReady;
  wire              pop  = outValid && outReady;
  assign inReady  = fill != (AW+1)'(DEPTH);
  assign outValid = fill != '0;
  assign outData  = mem[rdPtr[AW-1:0]];
  // pointer and storage update
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
    end
    else
    begin
      if (push) wrPtr <= wrPtr + 1'b1;
      if (pop) rdPtr <= rdPtr + 1'b1;
    end
    if (push) mem[wrPtr[AW-1:0]] <= inData;
  end
endmodule // pac_fifo

/* File: src/pac_acquisition.sv */
// Function
// [RL1] read-only 12-bit firmware revision in bits 11..0 of first register
// [RL2] line-valid delayed by 4-bit field pixel clocks, zero means none; field values 8 to 15 give 7 clocks here
// [RL3] read-only 4-bit firmware kind in bits 19..16
// [RL4] bit 20 set keeps only 8 low bits of each lane
// [RL5] software sets barrel shifter so wanted bits land in low byte
// [RL6] bit 21 clips pixels above 240 to 240, below 15 to 15
// [RL7] bit 22 is spare read/write with no effect
// [RL8] while bit 23 is one the calculated starting bank is cleared
// [RL9] calculated starting bank readable in bits 29..24
// [RL10] doubler 00 uses active clocks as is, 01 doubles it
// [RL11] bits 16..0 of second register set active clocks per line
// [RL12] software gives active clocks in camera clocks, not pixels
// [RL13] read-only 5-bit tap-layout code in bits 21..17
// [RL14] layout codes 0 to 7 are single-camera layouts
// [RL15] layout codes 8 to 12 are dual-camera layouts
// [RL16] layout codes 13 to 24 are eight-tap, mosaic, interleaved, inverted
// [RL17] reserved doubler codes behave as unmultiplied
//
// Our own choices: the AXI4-Lite slave port and the address map.
module pac_acquisition #(
  parameter logic [11:0] FW_REVISION = 12'h001, // arbitrary value
  parameter logic [3:0]  FW_KIND     = 4'h1,    // arbitrary value
  parameter logic [4:0]  TAP_LAYOUT  = 5'h00,
  parameter int          LANE_W      = 16,
  parameter int          FIFO_DEPTH  = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic [3:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [3:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  input  wire logic [LANE_W-1:0]   videoData,
  input  wire logic                videoLineValid,
  input  wire logic                bankAdvance,
  output logic [LANE_W-1:0]        pixelData,
  output logic                     pixelLineValid,
  output logic                     pixelValid,
  input  wire logic                pixelReady,
  output logic                     activeWindow,
  output logic                     overflow
);
  initial
  begin
    if (LANE_W < 8 || LANE_W > 16) $error("lane width must be 8..16");
    if (TAP_LAYOUT > 5'd24) $error("layout code must be 0..24");
  end

  // software fields
  logic [3:0]               delaySel;
  logic                     lowByte;
  logic                     clipOn;
  logic                     spareBit;
  logic                     bankClear;
  logic [1:0]               doubler;
  logic [pac_pkg::ACTIVE_CLOCKS_PER_LINE_W-1:0] activeClocks;
  logic [pac_pkg::BANK_W-1:0] startBank;

  // write channel: hold address and data until both are present
  logic        awHeld;
  logic        wHeld;
  logic [3:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  wire         doWrite = awHeld && wHeld && !s_axi_bvalid;
  wire         hitTrim = awAddr == pac_pkg::TRIM_BANK_ADDR;
  wire         hitLine = awAddr == pac_pkg::LINE_LAYOUT_ADDR;
  wire [31:0]  oldTrim = {doubler, startBank, bankClear, spareBit, clipOn, lowByte,
                          FW_KIND, delaySel, FW_REVISION};
  wire [31:0]  oldLine = {10'h000, TAP_LAYOUT, activeClocks};

  // merge byte lanes into a register word
  function automatic logic [31:0] mergeBytes(input logic [31:0] cur,
                                             input logic [31:0] val,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = cur;
    for (int i = 0; i < 4; i++)
      if (strb[i]) res[i*8 +: 8] = val[i*8 +: 8];
    return res;
  endfunction

  wire [31:0] newTrim = mergeBytes(oldTrim, wData, wStrb);
  wire [31:0] newLine = mergeBytes(oldLine, wData, wStrb);

  // address and data capture
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 4'h0;
      wData  <= 32'h0000_0000;
      wStrb  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
      end
      else if (doWrite)
        awHeld <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
      end
      else if (doWrite)
        wHeld <= 1'b0;
    end
  end

  // ready flags are registered and drop once a half is held
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= pac_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_awready <= !awHeld && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !wHeld && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (doWrite)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (hitTrim || hitLine) ? pac_pkg::RESP_OKAY : pac_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // writable fields; read-only bits ignore writes
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      delaySel     <= pac_pkg::TRIM_BANK_RST[pac_pkg::DELAY_LSB +: 4];
      lowByte      <= pac_pkg::TRIM_BANK_RST[pac_pkg::LOWBYTE_BIT];
      clipOn       <= pac_pkg::TRIM_BANK_RST[pac_pkg::CLIP_BIT];
      spareBit     <= pac_pkg::TRIM_BANK_RST[pac_pkg::SPARE_BIT];
      bankClear    <= pac_pkg::TRIM_BANK_RST[pac_pkg::CLEAR_BIT];
      doubler      <= pac_pkg::TRIM_BANK_RST[pac_pkg::DOUBLER_LSB +: 2];
      activeClocks <= pac_pkg::LINE_LAYOUT_RST[pac_pkg::ACTIVE_CLOCKS_PER_LINE_LSB +: pac_pkg::ACTIVE_CLOCKS_PER_LINE_W];
    end
    else if (doWrite && hitTrim)
    begin
      delaySel  <= newTrim[pac_pkg::DELAY_LSB +: 4];
      lowByte   <= newTrim[pac_pkg::LOWBYTE_BIT];
      clipOn    <= newTrim[pac_pkg::CLIP_BIT];
      // [RL7] spare bit stored
      spareBit  <= newTrim[pac_pkg::SPARE_BIT];
      bankClear <= newTrim[pac_pkg::CLEAR_BIT];
      doubler   <= newTrim[pac_pkg::DOUBLER_LSB +: 2];
    end
    else if (doWrite && hitLine)
      // [RL11] active clocks stored
      activeClocks <= newLine[pac_pkg::ACTIVE_CLOCKS_PER_LINE_LSB +: pac_pkg::ACTIVE_CLOCKS_PER_LINE_W];
  end

  // read channel, one cycle after the address is taken
  wire [3:0] rdAddr = s_axi_araddr;
  // [RL1] [RL3] [RL9] first register view
  // [RL13] [RL14] [RL15] [RL16] layout code view
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= pac_pkg::RESP_OKAY;
    end
    else
    begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= pac_pkg::RESP_OKAY;
        if (rdAddr == pac_pkg::TRIM_BANK_ADDR)
          s_axi_rdata <= oldTrim;
        else if (rdAddr == pac_pkg::LINE_LAYOUT_ADDR)
          s_axi_rdata <= oldLine;
        else
        begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= pac_pkg::RESP_SLVERR;
        end
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // pin inputs through two flip-flops
  logic [LANE_W-1:0] dataMeta;
  logic [LANE_W-1:0] dataSync;
  logic [1:0]        lvPipe;
  logic [1:0]        bankPipe;
  logic              bankPrev;
  always_ff @(posedge clk)
  begin
    dataMeta <= videoData;
    dataSync <= dataMeta;
    if (rst)
    begin
      lvPipe   <= 2'b00;
      bankPipe <= 2'b00;
      bankPrev <= 1'b0;
    end
    else
    begin
      lvPipe   <= {lvPipe[0], videoLineValid};
      bankPipe <= {bankPipe[0], bankAdvance};
      bankPrev <= bankPipe[1];
    end
  end

  // starting bank: counts bank advances
  always_ff @(posedge clk)
  begin
    if (rst)
      startBank <= '0;
    // [RL8] held clear while bit set
    else if (bankClear)
      startBank <= '0;
    else if (bankPipe[1] && !bankPrev)
      startBank <= startBank + 1'b1;
  end

  // line-valid delay line, 0..7 clocks
  logic [pac_pkg::MAX_DELAY:0] lvDelay;
  always_ff @(posedge clk)
  begin
    if (rst)
      lvDelay <= '0;
    else
      lvDelay <= {lvDelay[pac_pkg::MAX_DELAY-1:0], lvPipe[1]};
  end
  // [RL2] pick delayed window
  wire [2:0] delayIdx  = delaySel[3] ? 3'(pac_pkg::MAX_DELAY) : delaySel[2:0];
  wire       lvDelayed = delayIdx == 3'h0 ? lvPipe[1] : lvDelay[delayIdx - 3'h1];

  // horizontal window length
  // [RL10] [RL17] doubler decode, reserved codes unmultiplied
  wire [pac_pkg::ACTIVE_CLOCKS_PER_LINE_W:0] lineLen = (doubler == pac_pkg::MUL_TWO)
                                   ? {activeClocks, 1'b0} : {1'b0, activeClocks};
  logic [pac_pkg::ACTIVE_CLOCKS_PER_LINE_W:0] clkCount;
  logic                     lvPrev;
  wire  inWindow = lvDelayed && (clkCount < lineLen);
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clkCount <= '0;
      lvPrev   <= 1'b0;
    end
    else
    begin
      lvPrev <= lvDelayed;
      if (lvDelayed && !lvPrev)
        clkCount <= (pac_pkg::ACTIVE_CLOCKS_PER_LINE_W+1)'(1);
      else if (lvDelayed && clkCount != '1)
        clkCount <= clkCount + 1'b1;
    end
  end
  wire inWindowNow = lvDelayed && (!lvPrev ? lineLen != '0 : inWindow);

  // pixel conditioning
  // [RL4] low byte only
  wire [LANE_W-1:0] narrowed = lowByte ? {{(LANE_W-8){1'b0}}, dataSync[7:0]} : dataSync;
  // [RL6] clip gray levels
  wire [LANE_W-1:0] clipped =
    !clipOn ? narrowed :
    (narrowed > LANE_W'(pac_pkg::CLIP_HIGH)) ? LANE_W'(pac_pkg::CLIP_HIGH) :
    (narrowed < LANE_W'(pac_pkg::CLIP_LOW))  ? LANE_W'(pac_pkg::CLIP_LOW) : narrowed;

  // buffer toward the consumer
  logic [LANE_W:0] fifoOut;
  logic            fifoValid;
  logic            fifoReady;
  pac_fifo #(
    .WIDTH (LANE_W + 1),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .inData   ({lvDelayed, clipped}),
    .inValid  (inWindowNow),
    .inReady  (fifoReady),
    .outData  (fifoOut),
    .outValid (fifoValid),
    .outReady (pixelReady || !pixelValid)
  );

  // output stage and status flags
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pixelData      <= '0;
      pixelLineValid <= 1'b0;
      pixelValid     <= 1'b0;
      activeWindow   <= 1'b0;
      overflow       <= 1'b0;
    end
    else
    begin
      if (pixelReady || !pixelValid)
      begin
        pixelValid     <= fifoValid;
        pixelData      <= fifoOut[LANE_W-1:0];
        pixelLineValid <= fifoOut[LANE_W];
      end
      activeWindow <= inWindowNow;
      overflow     <= inWindowNow && !fifoReady;
    end
  end
endmodule // pac_acquisition

/* File: tb/pac_acquisition_asserts.sv */
module pac_acquisition_asserts #(
  parameter logic [11:0] FW_REVISION = 12'h001,
  parameter logic [3:0]  FW_KIND     = 4'h1,
  parameter logic [4:0]  TAP_LAYOUT  = 5'h00
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic [15:0] pixelData,
  input wire logic        pixelLineValid,
  input wire logic        pixelValid,
  input wire logic        pixelReady
);
  logic [3:0]  wrAddr;
  logic [3:0]  rdAddr;
  logic [31:0] wrData;
  logic [31:0] ctl;
  // read answers by register
  wire         rdZero = s_axi_rvalid && rdAddr == pac_pkg::TRIM_BANK_ADDR;
  wire         rdOne  = s_axi_rvalid && rdAddr == pac_pkg::LINE_LAYOUT_ADDR;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // shadow of the first register from completed writes
  always_ff @(posedge clk)
  begin
    if (s_axi_awvalid && s_axi_awready) wrAddr <= s_axi_awaddr;
    if (s_axi_wvalid && s_axi_wready) wrData <= s_axi_wdata;
    if (s_axi_arvalid && s_axi_arready) rdAddr <= s_axi_araddr;
    if (rst) ctl <= 32'h0;
    else if (s_axi_bvalid && s_axi_bready && s_axi_bresp == 2'h0 && wrAddr == 4'h0) ctl <= wrData;
  end
  // bus steps
  sequence wrTaken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence wrAnswer;
    ##[1:2] s_axi_bvalid;
  endsequence
  sequence arTaken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_write_answer: assert property (wrTaken |-> wrAnswer)
    else $error("write response late");
  a_read_answer: assert property (arTaken |=> s_axi_rvalid)
    else $error("read data late");
  a_rev_field: assert property (rdZero |-> s_axi_rdata[11:0] == FW_REVISION)
    else $error("revision field wrong");
  a_kind_field: assert property (rdZero |-> s_axi_rdata[19:16] == FW_KIND)
    else $error("kind field wrong");
  a_layout_field: assert property (rdOne |-> s_axi_rdata[21:17] == TAP_LAYOUT)
    else $error("layout field wrong");
  a_rw_fields: assert property (rdZero |-> (s_axi_rdata & 32'hC0F0F000) == (ctl & 32'hC0F0F000))
    else $error("writable field lost");
  a_bank_clear: assert property (rdZero && ctl[23] |-> s_axi_rdata[29:24] == 6'h00)
    else $error("bank not held clear");
  a_low_byte: assert property (pixelValid && ctl[20] |-> pixelData[15:8] == 8'h00)
    else $error("high byte passed");
  a_clip_range: assert property (pixelValid && ctl[21] |-> pixelData inside {[16'h000F:16'h00F0]})
    else $error("pixel outside clip range");
  a_pixel_hold: assert property (pixelValid && !pixelReady |=> pixelValid && $stable(pixelData))
    else $error("pixel dropped while stalled");
  a_tag_valid: assert property (pixelValid |-> pixelLineValid)
    else $error("pixel outside line window");
endmodule // pac_acquisition_asserts

bind pac_acquisition pac_acquisition_asserts #(
  .FW_REVISION(FW_REVISION),
  .FW_KIND(FW_KIND),
  .TAP_LAYOUT(TAP_LAYOUT)
) chk (.*);

/* File: tb/pac_camera_model.sv */
module pac_camera_model (
  input  wire logic   clk,
  output logic [15:0] videoData,
  output logic        videoLineValid
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] lineQ[$];
  initial
  begin
    videoData = 16'h0000;
    videoLineValid = 1'b0;
  end
  // one pixel a clock while queued, bus toggles between lines
  always @(posedge clk)
  begin
    videoLineValid <= lineQ.size() != 0;
    videoData      <= (lineQ.size() != 0) ? lineQ.pop_front() : ~videoData;
  end
endmodule // pac_camera_model

/* File: tb/tb_pixel_acquisition_control.sv */
module tb_pixel_acquisition_control;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [11:0] REV  = 12'h5A3; // arbitrary value
  localparam logic [3:0]  KIND = 4'h9;    // arbitrary value
  localparam logic [4:0]  LAY  = 5'h0D;
  localparam logic [1:0]  MD [3] = '{2'h2, 2'h1, 2'h3};
  localparam logic [15:0] VIN [3][4] = '{'{16'h000E, 16'h00F1, 16'h0080, 16'h000F},
    '{16'h1234, 16'h00FF, 16'hABCD, 16'h0001}, '{16'h12FE, 16'h0003, 16'h4580, 16'hF00F}};
  localparam logic [15:0] VEX [3][4] = '{'{16'h000F, 16'h00F0, 16'h0080, 16'h000F},
    '{16'h0034, 16'h00FF, 16'h00CD, 16'h0001}, '{16'h00F0, 16'h000F, 16'h0080, 16'h000F}};
  localparam int DL [4] = '{0, 3, 7, 15};
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, videoLineValid, bankAdvance, pixelLineValid, pixelValid;
  logic        pixelReady, activeWindow, overflow, ovSeen;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [15:0] videoData, pixelData;
  logic [15:0] gotQ[$], expQ[$];
  int          miscompares, testsRun, winCnt;

  pac_acquisition #(.FW_REVISION(REV), .FW_KIND(KIND), .TAP_LAYOUT(LAY)) dut (.*);
  pac_camera_model cam (.*);

  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    testsRun++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    s_axi_awaddr  <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    rd   = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic pix();
    while (cam.lineQ.size() != 0) @(posedge clk);
    repeat (30) @(posedge clk);
    chk(32'(gotQ.size()), 32'(expQ.size()));
    foreach (expQ[i]) chk({16'h0, gotQ[i]}, {16'h0, expQ[i]});
    gotQ = {};
    expQ = {};
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", testsRun, miscompares);
    if (miscompares == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  // accepted pixels and overflow flag
  always @(posedge clk)
  begin
    if (pixelValid && pixelReady) gotQ.push_back(pixelData);
    if (overflow) ovSeen <= 1'b1;
    if (activeWindow) winCnt++;
  end

  // hang guard
  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end

  initial
  begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
    s_axi_wstrb = 4'hF;
    {bankAdvance, ovSeen, rst, pixelReady} = 4'h3;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdr(4'h0); chk(rd, {12'h000, KIND, 4'h0, REV});
    rdr(4'h4); chk(rd, {10'h000, LAY, 17'h00000});
    chk(32'(pac_pkg::LAY_4Q_RI_BU), 32'h7);
    chk(32'(pac_pkg::LAY_2CAM_OEL), 32'hC);
    chk(32'(pac_pkg::LAY_10WI), 32'h18);
    wr(4'h0, 32'hFFFFFFFF); rdr(4'h0); chk(rd, {2'h3, 6'h00, 4'hF, KIND, 4'hF, REV});
    wr(4'h4, 32'hFFFFFFFF); chk({30'h0, resp}, {30'h0, pac_pkg::RESP_OKAY});
    rdr(4'h4); chk(rd, {10'h000, LAY, 17'h1FFFF});
    wr(4'h8, 32'h12345678); chk({30'h0, resp}, {30'h0, pac_pkg::RESP_SLVERR});
    rdr(4'h8); chk(rd, 32'h0);
    chk({30'h0, resp}, {30'h0, pac_pkg::RESP_SLVERR});
    wr(4'h0, 32'h0);
    repeat (3)
    begin
      bankAdvance <= 1'b1;
      repeat (4) @(posedge clk);
      bankAdvance <= 1'b0;
      repeat (4) @(posedge clk);
    end
    rdr(4'h0); chk(rd, {2'h0, 6'h03, 4'h0, KIND, 4'h0, REV});
    wr(4'h0, 32'h00800000); rdr(4'h0); chk(rd, {2'h0, 6'h00, 4'h8, KIND, 4'h0, REV});
    // line length and doubler codes
    // active clocks given in camera clocks, one pixel a clock
    wr(4'h4, 32'h4);
    for (int m = 0; m < 4; m++)
    begin
      wr(4'h0, {m[1:0], 30'h0});
      winCnt = 0;
      for (int i = 0; i < 12; i++) cam.lineQ.push_back(16'h0100 + 16'(i));
      for (int i = 0; i < ((m == 1) ? 8 : 4); i++) expQ.push_back(16'h0100 + 16'(i));
      pix();
      chk(32'(winCnt), (m == 1) ? 32'h8 : 32'h4);
    end
    // line valid delay, top code saturates
    foreach (DL[k])
    begin
      wr(4'h0, {16'h0, 4'(DL[k]), 12'h0});
      for (int i = 0; i < 12; i++) cam.lineQ.push_back(16'h0200 + 16'(i));
      for (int i = 0; i < 4; i++) expQ.push_back(16'h0200 + 16'((DL[k] > 7) ? 7 : DL[k]) + 16'(i));
      pix();
    end
    // clip and low byte modes, wanted bits already in the low byte
    // no shifting needed
    for (int t = 0; t < 3; t++)
    begin
      wr(4'h0, {10'h0, MD[t], 20'h0});
      for (int i = 0; i < 4; i++) cam.lineQ.push_back(VIN[t][i]);
      for (int i = 0; i < 4; i++) expQ.push_back(VEX[t][i]);
      pix();
    end
    // stalled output fills the buffer
    wr(4'h0, 32'h0);
    wr(4'h4, 32'h8);
    pixelReady <= 1'b0;
    for (int i = 0; i < 12; i++) cam.lineQ.push_back(16'h0300 + 16'(i));
    while (cam.lineQ.size() != 0) @(posedge clk);
    repeat (20) @(posedge clk);
    chk({31'h0, ovSeen}, 32'h1);
    pixelReady <= 1'b1;
    repeat (10) @(posedge clk);
    chk({31'h0, gotQ.size() < 8}, 32'h1);
    for (int i = 0; i < 4; i++) chk({16'h0, gotQ[i]}, 32'h0300 + 32'(i));
    test_done();
  end
endmodule // tb_pixel_acquisition_control
